// File: fwsr_pkg.sv
// package for the flash write-status polling controller
package fwsr_pkg;
    // register offsets (byte addresses on the wishbone slave)
    localparam logic [3:0] FWSR_CTRL_OFS = 4'h0;
    localparam logic [3:0] FWSR_ADDR_OFS = 4'h4;
    localparam logic [3:0] FWSR_STAT_OFS = 4'h8;
    localparam logic [3:0] FWSR_LAST_OFS = 4'hC;
    // ctrl register fields
    localparam int FWSR_CTRL_START = 0;
    localparam int FWSR_CTRL_ABORT = 1;
    localparam int FWSR_CTRL_SECT = 2;
    // status register fields
    localparam int FWSR_ST_BUSY = 0;
    localparam int FWSR_ST_DONE = 1;
    localparam int FWSR_ST_FAIL = 2;
    localparam int FWSR_ST_RDY = 3;
    localparam int FWSR_ST_WIN = 4;
    // status bit positions on the flash data bus
    localparam int FWSR_POLL_BIT = 7;
    localparam int FWSR_GTOG_BIT = 6;
    localparam int FWSR_TOUT_BIT = 5;
    localparam int FWSR_WIN_BIT = 3;
    localparam int FWSR_STOG_BIT = 2;
    // flash reset command
    localparam logic [7:0] FWSR_RESET_CMD = 8'hF0;
    // read and write strobe timing, ns, at 4 ns clock
    localparam int FWSR_CLK_NS = 4;
    localparam int FWSR_RD_NS = 70;
    localparam int FWSR_WR_NS = 35;
    localparam int FWSR_RD_CYC = (FWSR_RD_NS + FWSR_CLK_NS - 1) / FWSR_CLK_NS;
    localparam int FWSR_WR_CYC = (FWSR_WR_NS + FWSR_CLK_NS - 1) / FWSR_CLK_NS;
    typedef enum logic [2:0] {
        FWSR_IDLE, FWSR_RD_LOW, FWSR_RD_HOLD, FWSR_EVAL, FWSR_WR_LOW, FWSR_WR_HOLD
    } fwsr_state_t;
endpackage : fwsr_pkg

// File: fwsr_ctrl.sv
// flash write-status polling controller with a wishbone register slave
`timescale 1ns/1ps
module fwsr_ctrl
    import fwsr_pkg::*;
#(
    parameter int AW = 20
) (
    input wire logic clk_i,                 // 250 MHz clock
    input wire logic rst_i,                 // sync reset, active high
    input wire logic [3:0] wb_adr_i,        // wishbone byte address
    input wire logic [31:0] wb_dat_i,       // wishbone write data
    output logic [31:0] wb_dat_o,           // wishbone read data
    input wire logic wb_we_i,               // wishbone write enable
    input wire logic [3:0] wb_sel_i,        // wishbone byte selects
    input wire logic wb_cyc_i,              // wishbone cycle
    input wire logic wb_stb_i,              // wishbone strobe
    output logic wb_ack_o,                  // wishbone acknowledge
    output logic [AW-1:0] flash_addr_o,     // flash address
    input wire logic [7:0] flash_dq_i,      // flash data in
    output logic [7:0] flash_dq_o,          // flash data out
    output logic flash_dq_oe_o,             // flash data drive enable
    output logic chip_select_n_o,           // flash chip select, low
    output logic output_strobe_n_o,         // flash output enable, low
    output logic write_strobe_n_o,          // flash write strobe, low
    input wire logic ready_busy_n_i         // pulled-up ready/busy line
);
    fwsr_state_t state_reg, state_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [7:0] last_reg, last_next, first_reg, first_next;
    logic [1:0] nrd_reg, nrd_next;
    logic recheck_reg, recheck_next;
    logic sect_reg, sect_next;
    logic done_reg, done_next, fail_reg, fail_next;
    logic [7:0] cnt_reg, cnt_next;
    logic cs_reg, cs_next, oe_reg, oe_next, we_reg, we_next, doe_reg, doe_next;
    logic [7:0] dout_reg, dout_next;
    logic rdy_reg, win_reg;
    logic [31:0] rdat_reg, rdat_next;
    logic ack_reg, ack_next;
    logic wr_hit, tog_chg;

    // writes land at the edge where the master sees ack high
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
    // sector toggle optional
    // compare stored samples: the data bus is not driven once the strobes rise
    assign tog_chg = (first_reg[FWSR_GTOG_BIT] != last_reg[FWSR_GTOG_BIT])
        || (sect_reg && (first_reg[FWSR_STOG_BIT] != last_reg[FWSR_STOG_BIT]));

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        last_next = last_reg;
        first_next = first_reg;
        nrd_next = nrd_reg;
        recheck_next = recheck_reg;
        sect_next = sect_reg;
        done_next = done_reg;
        fail_next = fail_reg;
        cnt_next = cnt_reg;
        cs_next = cs_reg;
        oe_next = oe_reg;
        we_next = we_reg;
        doe_next = doe_reg;
        dout_next = dout_reg;
        if (wr_hit && wb_adr_i == FWSR_ADDR_OFS && state_reg == FWSR_IDLE) begin
            addr_next = wb_dat_i[AW-1:0];
        end
        case (state_reg)
            FWSR_IDLE: begin
                if (wr_hit && wb_adr_i == FWSR_CTRL_OFS && wb_dat_i[FWSR_CTRL_START]) begin
                    nrd_next = 2'h0;
                    recheck_next = 1'b0;
                    done_next = 1'b0;
                    fail_next = 1'b0;
                    sect_next = wb_dat_i[FWSR_CTRL_SECT];
                    cs_next = 1'b0;
                    oe_next = 1'b0;
                    cnt_next = 8'(FWSR_RD_CYC);
                    state_next = FWSR_RD_LOW;
                end
            end
            FWSR_RD_LOW: begin
                if (cnt_reg == 8'h1) begin
                    last_next = flash_dq_i;
                    if (nrd_reg == 2'h0) begin
                        first_next = flash_dq_i;
                    end
                    cs_next = 1'b1;
                    oe_next = 1'b1;
                    cnt_next = 8'(FWSR_RD_CYC);
                    state_next = (nrd_reg == 2'h0) ? FWSR_RD_HOLD : FWSR_EVAL;
                    nrd_next = nrd_reg + 2'h1;
                end else begin
                    cnt_next = cnt_reg - 8'h1;
                end
            end
            FWSR_RD_HOLD: begin
                // high time between reads so every read is a new strobe
                if (wr_hit && wb_adr_i == FWSR_CTRL_OFS && wb_dat_i[FWSR_CTRL_ABORT]) begin
                    state_next = FWSR_IDLE;
                end else if (cnt_reg == 8'h1) begin
                    cs_next = 1'b0;
                    oe_next = 1'b0;
                    cnt_next = 8'(FWSR_RD_CYC);
                    state_next = FWSR_RD_LOW;
                end else begin
                    cnt_next = cnt_reg - 8'h1;
                end
            end
            FWSR_EVAL: begin
                cnt_next = 8'(FWSR_RD_CYC);
                if (wr_hit && wb_adr_i == FWSR_CTRL_OFS && wb_dat_i[FWSR_CTRL_ABORT]) begin
                    state_next = FWSR_IDLE;
                end else if (!tog_chg) begin
                    done_next = 1'b1;
                    state_next = FWSR_IDLE;
                end else if (recheck_reg) begin
                    fail_next = 1'b1;
                    cs_next = 1'b0;
                    we_next = 1'b0;
                    doe_next = 1'b1;
                    dout_next = FWSR_RESET_CMD;
                    cnt_next = 8'(FWSR_WR_CYC);
                    state_next = FWSR_WR_LOW;
                end else begin
                    recheck_next = last_reg[FWSR_TOUT_BIT];
                    first_next = last_reg;
                    nrd_next = 2'h1;
                    // keep the strobes high for a full gap before the next read
                    state_next = FWSR_RD_HOLD;
                end
            end
            FWSR_WR_LOW: begin
                if (cnt_reg == 8'h1) begin
                    cs_next = 1'b1;
                    we_next = 1'b1;
                    cnt_next = 8'(FWSR_WR_CYC);
                    state_next = FWSR_WR_HOLD;
                end else begin
                    cnt_next = cnt_reg - 8'h1;
                end
            end
            FWSR_WR_HOLD: begin
                if (cnt_reg == 8'h1) begin
                    doe_next = 1'b0;
                    state_next = FWSR_IDLE;
                end else begin
                    cnt_next = cnt_reg - 8'h1;
                end
            end
            default: begin
                state_next = FWSR_IDLE;
            end
        endcase
    end

    always_comb begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        rdat_next = 32'h0;
        case (wb_adr_i)
            FWSR_ADDR_OFS: rdat_next = 32'(addr_reg);
            FWSR_STAT_OFS: begin
                rdat_next[FWSR_ST_BUSY] = (state_reg != FWSR_IDLE);
                rdat_next[FWSR_ST_DONE] = done_reg;
                rdat_next[FWSR_ST_FAIL] = fail_reg;
                rdat_next[FWSR_ST_RDY] = rdy_reg;
                rdat_next[FWSR_ST_WIN] = win_reg;
            end
            FWSR_LAST_OFS: rdat_next = {24'h0, last_reg};
            default: rdat_next = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= FWSR_IDLE;
            addr_reg <= '0;
            last_reg <= 8'h0;
            first_reg <= 8'h0;
            nrd_reg <= 2'h0;
            recheck_reg <= 1'b0;
            sect_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            cnt_reg <= 8'h0;
            cs_reg <= 1'b1;
            oe_reg <= 1'b1;
            we_reg <= 1'b1;
            doe_reg <= 1'b0;
            dout_reg <= 8'h0;
            rdy_reg <= 1'b1;
            win_reg <= 1'b0;
            rdat_reg <= 32'h0;
            ack_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            last_reg <= last_next;
            first_reg <= first_next;
            nrd_reg <= nrd_next;
            recheck_reg <= recheck_next;
            sect_reg <= sect_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
            cnt_reg <= cnt_next;
            cs_reg <= cs_next;
            oe_reg <= oe_next;
            we_reg <= we_next;
            doe_reg <= doe_next;
            dout_reg <= dout_next;
            rdy_reg <= ready_busy_n_i;
            win_reg <= last_reg[FWSR_WIN_BIT];
            rdat_reg <= rdat_next;
            ack_reg <= ack_next;
        end
    end

    assign wb_dat_o = rdat_reg;
    assign wb_ack_o = ack_reg;
    assign flash_addr_o = addr_reg;
    assign flash_dq_o = dout_reg;
    assign flash_dq_oe_o = doe_reg;
    assign chip_select_n_o = cs_reg;
    assign output_strobe_n_o = oe_reg;
    assign write_strobe_n_o = we_reg;
endmodule : fwsr_ctrl

// File: fwsr_chk.sv
// port checker for the flash status poller
`timescale 1ns/1ps
module fwsr_chk
    import fwsr_pkg::*;
#(
    parameter int AW = 20
) (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_ack_o, // ack
    input wire logic [AW-1:0] flash_addr_o, // flash address
    input wire logic [7:0] flash_dq_o, // data out
    input wire logic flash_dq_oe_o, // drive enable
    input wire logic chip_select_n_o, // select
    input wire logic output_strobe_n_o, // read strobe
    input wire logic write_strobe_n_o // write strobe
);
    logic [7:0] rd_cnt_reg, rd_cnt_next, wr_cnt_reg, wr_cnt_next;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // strobe widths exceed the repetition limit, so count them
    always_comb begin
        rd_cnt_next = output_strobe_n_o ? 8'h00 : rd_cnt_reg + 8'h01;
        wr_cnt_next = write_strobe_n_o ? 8'h00 : wr_cnt_reg + 8'h01;
    end
    always_ff @(posedge clk_i) begin
        rd_cnt_reg <= rst_i ? 8'h00 : rd_cnt_next;
        wr_cnt_reg <= rst_i ? 8'h00 : wr_cnt_next;
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_reply_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    read_width_a: assert property ($rose(output_strobe_n_o) |-> rd_cnt_reg == FWSR_RD_CYC)
        else $error("read strobe width wrong");
    read_gap_a: assert property ($rose(output_strobe_n_o) |-> output_strobe_n_o [*8])
        else $error("read strobes too close");
    read_bus_a: assert property (!output_strobe_n_o |-> !chip_select_n_o && !flash_dq_oe_o)
        else $error("read without select or with bus driven");
    addr_hold_a: assert property (!output_strobe_n_o |-> $stable(flash_addr_o))
        else $error("address moved during read");
    reset_cmd_a: assert property (!write_strobe_n_o |->
        flash_dq_oe_o && flash_dq_o == FWSR_RESET_CMD && output_strobe_n_o)
        else $error("write is not the reset command");
    write_width_a: assert property ($rose(write_strobe_n_o) |-> wr_cnt_reg == FWSR_WR_CYC)
        else $error("write strobe width wrong");
endmodule : fwsr_chk

// File: fwsr_flash.sv
// behavioural flash status model for the poller bench
`timescale 1ns/1ps
module fwsr_flash (
    input wire logic clk_i, // bench clock, samples write data
    input wire logic chip_select_n_i, // select
    input wire logic output_strobe_n_i, // read strobe
    input wire logic write_strobe_n_i, // write strobe
    input wire logic [7:0] dq_i, // data from host
    output logic [7:0] dq_o, // data to host
    output logic ready_busy_n_o // line level after pull-up
);
    int busy_left = 0; // toggling reads left
    int reads = 0;
    int resets = 0;
    logic stuck = 1'b0; // timed out, waits for reset
    logic sect = 1'b0; // erase suspended: only sector bit toggles
    logic win = 1'b0;
    logic act = 1'b0;
    logic gtog = 1'b0;
    logic stog = 1'b0;
    logic [7:0] cur = 8'h00;
    logic [7:0] wr_q = 8'h00;
    wire rd_n = chip_select_n_i | output_strobe_n_i;
    // low while active, released in suspend
    assign ready_busy_n_o = !(((busy_left > 0) || stuck) && !sect);
    // idle bus shows the inverse so stale data cannot pass
    assign dq_o = rd_n ? ~cur : cur;
    always @(negedge rd_n) begin
        reads++;
        act = (busy_left > 0) || stuck;
        if (act && !sect) gtog = ~gtog;
        if (act && sect) stog = ~stog;
        cur = {~act | sect, gtog, stuck, 1'b0, win, stog, 2'b00};
        if (busy_left > 0) busy_left--;
    end
    always @(posedge clk_i) if (!write_strobe_n_i && !chip_select_n_i) wr_q <= dq_i;
    always @(posedge write_strobe_n_i) begin
        if (wr_q == 8'hF0 && !(win && busy_left > 0)) begin
            stuck = 1'b0;
            busy_left = 0;
            resets++;
        end
    end
endmodule : fwsr_flash

// File: tb_top.sv
// top testbench for the flash status poller
`timescale 1ns/1ps
module tb_top;
    import fwsr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, got;
    logic [19:0] faddr;
    logic [7:0] dq_in, dq_out, fdq;
    logic ack, dq_oe, cs_n, oe_n, we_n, rb_n;
    int failures = 0;
    int checks_done = 0;
    always #2 clk_i = ~clk_i;
    fwsr_ctrl #(.AW(20)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_ack_o(ack), .flash_addr_o(faddr), .flash_dq_i(dq_in), .flash_dq_o(dq_out),
        .flash_dq_oe_o(dq_oe), .chip_select_n_o(cs_n), .output_strobe_n_o(oe_n),
        .write_strobe_n_o(we_n), .ready_busy_n_i(rb_n));
    fwsr_flash flash (.clk_i(clk_i), .chip_select_n_i(cs_n), .output_strobe_n_i(oe_n),
        .write_strobe_n_i(we_n), .dq_i(dq_in), .dq_o(fdq), .ready_busy_n_o(rb_n));
    assign dq_in = dq_oe ? dq_out : fdq;
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            failures++;
            results();
        end
    endtask : bus
    task automatic idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, FWSR_STAT_OFS, 32'h0);
            n++;
        end while (got[FWSR_ST_BUSY] !== 1'b0 && n < 3000);
        if (n >= 3000) begin
            failures++;
            results();
        end
    endtask : idle
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, FWSR_STAT_OFS, 32'h0);
        chk("stat idle", 32'h8, got);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, got);
        bus(1'b1, FWSR_ADDR_OFS, 32'h5A5A5);
        bus(1'b0, FWSR_ADDR_OFS, 32'h0);
        chk("addr", 32'h5A5A5, got);
        chk("pin addr", 32'h5A5A5, {12'h0, faddr});
        bus(1'b1, FWSR_CTRL_OFS, 32'h1);
        idle();
        chk("stat ready", 32'hA, got);
        chk("read count", 32'h2, flash.reads);
        flash.busy_left = 5;
        bus(1'b0, FWSR_STAT_OFS, 32'h0);
        chk("stat busy line", 32'h2, got);
        bus(1'b1, FWSR_CTRL_OFS, 32'h1);
        bus(1'b1, FWSR_ADDR_OFS, 32'h00011);
        bus(1'b0, FWSR_ADDR_OFS, 32'h0);
        chk("addr held", 32'h5A5A5, got);
        idle();
        chk("stat after busy", 32'hA, got);
        chk("toggles spent", 32'h0, flash.busy_left);
        flash.sect = 1'b1;
        flash.win = 1'b1;
        flash.busy_left = 4;
        bus(1'b1, FWSR_CTRL_OFS, 32'h5);
        idle();
        chk("stat sector", 32'h1A, got);
        chk("sector toggles", 32'h0, flash.busy_left);
        flash.sect = 1'b0;
        flash.win = 1'b0;
        flash.busy_left = 40;
        bus(1'b1, FWSR_CTRL_OFS, 32'h1);
        repeat (8) bus(1'b1, FWSR_CTRL_OFS, 32'h2);
        bus(1'b0, FWSR_STAT_OFS, 32'h0);
        chk("stat abort", 32'h0, got & 32'h3);
        flash.busy_left = 0;
        flash.stuck = 1'b1;
        bus(1'b1, FWSR_CTRL_OFS, 32'h1);
        idle();
        repeat (18) @(posedge clk_i);
        chk("fail flag", 32'h1, {31'h0, got[FWSR_ST_FAIL]});
        chk("reset cmds", 32'h1, flash.resets);
        chk("line free", 32'h1, {31'h0, rb_n});
        results();
    end
endmodule : tb_top
bind fwsr_ctrl fwsr_chk #(.AW(AW)) chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_addr_o(flash_addr_o),
    .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .chip_select_n_o(chip_select_n_o),
    .output_strobe_n_o(output_strobe_n_o), .write_strobe_n_o(write_strobe_n_o));
